//--- src/vcs_pkg.sv
package vcs_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;      // Write 1 to bit 0 starts a run
    localparam logic [7:0]  ADDR_TIMEOUT = 8'h04;      // Shared timeout count
    localparam logic [7:0]  ADDR_COUNTS  = 8'h08;      // Settle and level-wait counts
    localparam logic [7:0]  ADDR_BANDDIV = 8'h0C;      // Band select divider
    localparam logic [7:0]  ADDR_STATUS  = 8'h10;      // Busy, done, phase
    localparam int          TIMEOUT_W    = 10;         // Timeout field width
    localparam int          COUNT_W      = 5;          // Settle and level-wait width
    localparam int          BANDDIV_W    = 8;          // Band divider width
    localparam int          SETTLE_LSB   = 0;          // Settle count field position
    localparam int          LEVEL_LSB    = 8;          // Level-wait field position
    localparam int          BUSY_BIT     = 0;          // Status busy bit
    localparam int          DONE_BIT     = 1;          // Status done bit
    localparam int          PHASE_LSB    = 4;          // Status phase field position
    localparam logic [9:0]  TIMEOUT_RST  = 10'h067;    // Timeout reset value
    localparam logic [4:0]  SETTLE_RST   = 5'h0C;      // Settle count reset value
    localparam logic [4:0]  LEVEL_RST    = 5'h1E;      // Level-wait reset value
    localparam logic [7:0]  BANDDIV_RST  = 8'h1A;      // Band divider reset value
    localparam logic [4:0]  BAND_MULT    = 5'h10;      // Divider multiplier
    localparam logic [3:0]  BAND_CYCLES  = 4'hB;       // Band selection cycles
    localparam logic [5:0]  LEVEL_MULT   = 6'h37;      // Level phase multiplier
    localparam logic [1:0]  RESP_OKAY    = 2'h0;       // AXI OKAY
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;       // AXI SLVERR
    // ------------------------------------------------------------
    // Phase states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        VCS_IDLE   = 2'b00,
        VCS_SETTLE = 2'b01,
        VCS_BAND   = 2'b10,
        VCS_LEVEL  = 2'b11
    } vcs_phase_t;
endpackage : vcs_pkg

//--- src/vcs_tick_if.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Tick divider carrier
// ------------------------------------------------------------
interface vcs_tick_if;
    logic        run;      // Divider runs while high
    logic [15:0] period;   // Cycles per tick
    logic        tick;     // One-cycle tick pulse
    modport ctl (output run, output period, input tick);
    modport div (input run, input period, output tick);
endinterface : vcs_tick_if

//--- src/vcs_tick_div.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Divider: one tick every period cycles while run
// ------------------------------------------------------------
module vcs_tick_div (
    input wire logic clk,
    input wire logic rst_n,
    vcs_tick_if.div  t
);
    typedef struct packed {
        logic [15:0] cnt;  // Cycles since last tick
        logic        tick; // Registered tick
    } vcs_div_t;
    vcs_div_t st;
    vcs_div_t next_st;

    // Count up, wrap and pulse at period
    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (!t.run) begin
            next_st.cnt = 16'h0000;
        end else if (st.cnt + 16'h0001 >= t.period) begin
            next_st.cnt  = 16'h0000;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 16'h0001;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign t.tick = st.tick;

    // A period of zero or one ticks every cycle, any other spaces ticks out
    tick_spacing_a: assert property (@(posedge clk) disable iff (!rst_n)
        st.tick && t.run |=> !st.tick || t.period <= 16'h0001)
        else $error("tick came too soon");
endmodule : vcs_tick_div

//--- src/vcs_top.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Calibration timing sequencer with AXI4-Lite registers
// ------------------------------------------------------------
module vcs_top (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             cal_busy,
    output logic             cal_done
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic              aw_got;   // Write address captured
        logic [7:0]        aw_addr;  // Captured write address
        logic              w_got;    // Write data captured
        logic [31:0]       w_data;   // Captured write data
        logic [3:0]        w_strb;   // Captured strobes
        logic              bvalid;   // Write response pending
        logic [1:0]        bresp;    // Write response code
        logic              rvalid;   // Read data pending
        logic [31:0]       rdata;    // Read data
        logic [1:0]        rresp;    // Read response code
        logic [9:0]        timeout;  // Shared timeout
        logic [4:0]        settle;   // Settle count
        logic [4:0]        level;    // Level-wait count
        logic [7:0]        banddiv;  // Band select divider
        vcs_pkg::vcs_phase_t phase;  // Current phase
        logic [9:0]        tcnt;     // Cycles within one timeout unit
        logic [10:0]       ucnt;     // Timeout units elapsed
        logic [3:0]        bcnt;     // Band cycles elapsed
        logic              done;     // Sticky completion
        logic              busy;     // Registered busy flag
    } vcs_state_t;
    vcs_state_t st;
    vcs_state_t next_st;

    vcs_tick_if tk ();    // Band clock divider link
    logic         wr_go;  // Write fires this cycle
    logic [31:0]  wmask;  // Byte mask from strobes
    logic         t_end;  // Last cycle of a timeout unit
    logic [10:0]  ulim;   // Units needed by present phase

    vcs_tick_div u_band_div (
        .clk   (clk),
        .rst_n (rst_n),
        .t     (tk)
    );

    // Band clock period is divider times 16 cycles
    assign tk.run    = (st.phase == vcs_pkg::VCS_BAND);
    assign tk.period = 16'(st.banddiv) * 16'(vcs_pkg::BAND_MULT);

    // Write and strobe helpers
    // A new write waits until the last response was taken
    assign wr_go = st.aw_got && st.w_got && !st.bvalid;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{st.w_strb[i]}};
        end
    end
    // A timeout of zero ends every unit at once, as a timeout of one would
    assign t_end = (st.tcnt + 10'h001 >= st.timeout);

    // Units per phase: settle count, or 55 times level wait
    always_comb begin
        ulim = 11'h000;
        if (st.phase == vcs_pkg::VCS_SETTLE) begin
            ulim = 11'(st.settle);
        end else if (st.phase == vcs_pkg::VCS_LEVEL) begin
            ulim = 11'(st.level) * 11'(vcs_pkg::LEVEL_MULT);
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] merged;
        merged  = 32'h0000_0000;
        next_st = st;
        // Address and data channels accepted independently
        if (s_axi_awvalid && !st.aw_got) begin
            next_st.aw_got  = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_got) begin
            next_st.w_got  = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        // Sequencer runs
        unique case (st.phase)
            vcs_pkg::VCS_IDLE: begin
                next_st.tcnt = 10'h000;
                next_st.ucnt = 11'h000;
                next_st.bcnt = 4'h0;
            end
            vcs_pkg::VCS_SETTLE, vcs_pkg::VCS_LEVEL: begin
                // Timeout units counted, phase ends at limit
                if (t_end) begin
                    next_st.tcnt = 10'h000;
                    if (st.ucnt + 11'h001 >= ulim) begin
                        next_st.ucnt  = 11'h000;
                        if (st.phase == vcs_pkg::VCS_SETTLE) begin
                            next_st.phase = vcs_pkg::VCS_BAND;
                        end else begin
                            next_st.phase = vcs_pkg::VCS_IDLE;
                            next_st.done  = 1'b1;
                        end
                    end else begin
                        next_st.ucnt = st.ucnt + 11'h001;
                    end
                end else begin
                    next_st.tcnt = st.tcnt + 10'h001;
                end
            end
            vcs_pkg::VCS_BAND: begin
                // Eleven divided cycles, then level phase
                // The registered tick adds one cycle to the phase
                if (tk.tick) begin
                    if (st.bcnt + 4'h1 >= vcs_pkg::BAND_CYCLES) begin
                        next_st.bcnt  = 4'h0;
                        next_st.phase = vcs_pkg::VCS_LEVEL;
                    end else begin
                        next_st.bcnt = st.bcnt + 4'h1;
                    end
                end
            end
        endcase
        // Register write
        if (wr_go) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = vcs_pkg::RESP_OKAY;
            unique case (st.aw_addr)
                vcs_pkg::ADDR_CTRL: begin
                    // Start ignored while a run is under way
                    if (st.w_strb[0] && st.w_data[0] &&
                        st.phase == vcs_pkg::VCS_IDLE) begin
                        next_st.phase = vcs_pkg::VCS_SETTLE;
                        next_st.done  = 1'b0;
                    end
                end
                vcs_pkg::ADDR_TIMEOUT: begin
                    merged          = (32'(st.timeout) & ~wmask) | (st.w_data & wmask);
                    next_st.timeout = merged[9:0];
                end
                vcs_pkg::ADDR_COUNTS: begin
                    merged = ({19'h0, st.level, 3'h0, st.settle} & ~wmask)
                             | (st.w_data & wmask);
                    next_st.settle = merged[vcs_pkg::SETTLE_LSB +: vcs_pkg::COUNT_W];
                    next_st.level  = merged[vcs_pkg::LEVEL_LSB +: vcs_pkg::COUNT_W];
                end
                vcs_pkg::ADDR_BANDDIV: begin
                    merged          = (32'(st.banddiv) & ~wmask) | (st.w_data & wmask);
                    next_st.banddiv = merged[7:0];
                end
                vcs_pkg::ADDR_STATUS: begin
                end
                default: begin
                    next_st.bresp = vcs_pkg::RESP_SLVERR;
                end
            endcase
        end
        // Register read
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = vcs_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                vcs_pkg::ADDR_CTRL:    next_st.rdata = 32'h0000_0000;
                vcs_pkg::ADDR_TIMEOUT: next_st.rdata = 32'(st.timeout);
                vcs_pkg::ADDR_COUNTS:  next_st.rdata = {19'h0, st.level, 3'h0, st.settle};
                vcs_pkg::ADDR_BANDDIV: next_st.rdata = 32'(st.banddiv);
                vcs_pkg::ADDR_STATUS:  next_st.rdata = {26'h0, st.phase, 2'h0, st.done,
                                                        st.phase != vcs_pkg::VCS_IDLE};
                default: begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = vcs_pkg::RESP_SLVERR;
                end
            endcase
        end
        // Busy kept in a flop so the pin carries no decode
        next_st.busy = (next_st.phase != vcs_pkg::VCS_IDLE);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st         <= '0;
            st.timeout <= vcs_pkg::TIMEOUT_RST;
            st.settle  <= vcs_pkg::SETTLE_RST;
            st.level   <= vcs_pkg::LEVEL_RST;
            st.banddiv <= vcs_pkg::BANDDIV_RST;
            st.phase   <= vcs_pkg::VCS_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign s_axi_awready = !st.aw_got;
    assign s_axi_wready  = !st.w_got;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;
    assign cal_busy      = st.busy;
    assign cal_done      = st.done;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Band phase is entered only from the settle phase
    settle_order_a: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(st.phase) && st.phase == vcs_pkg::VCS_BAND
        |-> $past(st.phase) == vcs_pkg::VCS_SETTLE)
        else $error("band phase not entered from settle");
    // Band counter never reaches eleven inside the phase
    band_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        st.phase == vcs_pkg::VCS_BAND |-> st.bcnt < vcs_pkg::BAND_CYCLES)
        else $error("band cycle count out of range");
    // Level phase follows the eleventh divided tick
    band_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(st.phase) == vcs_pkg::VCS_BAND && st.phase == vcs_pkg::VCS_LEVEL
        |-> $past(st.bcnt) == 4'hA && $past(tk.tick))
        else $error("band phase left early");
    // Leaving the level phase raises done
    level_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(st.phase) == vcs_pkg::VCS_LEVEL && st.phase == vcs_pkg::VCS_IDLE
        |-> st.done)
        else $error("done not set after level phase");
    // A run starts only from idle, never from a later phase
    retrig_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        st.phase == vcs_pkg::VCS_SETTLE && $past(st.phase) != vcs_pkg::VCS_SETTLE
        |-> $past(st.phase) == vcs_pkg::VCS_IDLE)
        else $error("retrigger during run");
    // Done rises only at the end of the level phase
    done_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(st.done) |-> $past(st.phase) == vcs_pkg::VCS_LEVEL)
        else $error("done raised outside level phase");
    // A new start clears done
    done_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        st.phase == vcs_pkg::VCS_SETTLE && $past(st.phase) == vcs_pkg::VCS_IDLE |-> !st.done)
        else $error("done kept over a new start");
    // Level unit counter stays below its limit
    unit_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
        st.phase == vcs_pkg::VCS_LEVEL && st.level != 5'h00
        |-> st.ucnt < 11'(st.level) * 11'(vcs_pkg::LEVEL_MULT))
        else $error("level unit count past limit");
    // Responses stand until the master takes them
    resp_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    read_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    // Write answer only once address and data are both held
    wr_order_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
        else $error("write answered before both channels");
    // Read answer only after an address was taken
    rd_order_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
        else $error("read answered without address");

    // ------------------------------------------------------------
    // Covers
    // ------------------------------------------------------------
    run_cover_c:  cover property (@(posedge clk) disable iff (!rst_n) $rose(cal_done));
    settle_cover_c: cover property (@(posedge clk) disable iff (!rst_n)
        $past(st.phase) == vcs_pkg::VCS_SETTLE && st.phase == vcs_pkg::VCS_BAND);
    retrig_cover_c: cover property (@(posedge clk) disable iff (!rst_n)
        wr_go && st.aw_addr == vcs_pkg::ADDR_CTRL && st.phase != vcs_pkg::VCS_IDLE);
    band_cover_c: cover property (@(posedge clk) disable iff (!rst_n)
        st.phase == vcs_pkg::VCS_BAND && tk.tick);
    err_cover_c:  cover property (@(posedge clk) disable iff (!rst_n)
        s_axi_rvalid && s_axi_rresp == vcs_pkg::RESP_SLVERR);
endmodule : vcs_top

//--- verif/vcs_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host side: AXI4-Lite master that programs the sequencer
// ------------------------------------------------------------
module vcs_host_model (
    input  wire logic        clk,
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready,
    output logic             hang
);
    // Idle bus, no request pending
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, hang} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
    end
    // Band divider keeping the band clock under 150 kHz
    function automatic logic [7:0] div_for(input int fpd);
        return 8'((fpd + 2399999) / 2400000);
    endfunction : div_for
    // Timeout so that timeout*settle covers 20 us at 20 MHz
    function automatic logic [9:0] to_for(input logic [4:0] st);
        return 10'((400 + st - 1) / st);
    endfunction : to_for
    // Level wait of about 2.5 times the settle count, 5 bits
    function automatic logic [4:0] lvl_for(input logic [4:0] st);
        return 5'((st * 5 + 1) / 2);
    endfunction : lvl_for
    // Write: sample at the falling edge, act at the rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        logic [1:0] br;
        int n;
        r = 2'h3;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            br = bresp;
            @(posedge clk);
            // Released payload shows the inverse, not a stale copy
            if (ta) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (tw) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
            if (tb) begin
                bready <= 1'b0;
                r = br;
                break;
            end
        end
        if (n == 100) hang <= 1'b1;
    endtask : wr
    // Read: address, then hold rready until data arrives
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(negedge clk);
            ta = arvalid && arready;
            tr = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (tr) begin
                rready <= 1'b0;
                break;
            end
        end
        if (n == 100) hang <= 1'b1;
    endtask : rd
endmodule : vcs_host_model

//--- verif/vcs_top_bench.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bench for the calibration sequencer
// ------------------------------------------------------------
module vcs_top_bench;
    logic        clk, rst_n, hang, cal_busy, cal_done;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    int          mismatches = 0;
    int          n_tests = 0;
    int          busy_n = 0;
    vcs_top u_dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cal_busy(cal_busy), .cal_done(cal_done));
    vcs_host_model u_host (.clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .hang);
    // Clock and busy-cycle counter
    initial clk = 1'b0;
    always #25 clk = ~clk;
    always @(negedge clk) if (cal_busy === 1'b1) busy_n++;
    // A stuck handshake ends the run
    always @(posedge clk) if (hang === 1'b1) begin
        mismatches++;
        end_sim();
    end
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Reset values, field widths and unmapped places
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        u_host.rd(vcs_pkg::ADDR_TIMEOUT, d, r);
        check(d, 32'h67);
        check({cal_busy, cal_done}, 0);
        u_host.rd(vcs_pkg::ADDR_COUNTS, d, r);
        check(d, 32'h1E0C);
        u_host.rd(vcs_pkg::ADDR_BANDDIV, d, r);
        check(d, 32'h1A);
        u_host.rd(vcs_pkg::ADDR_STATUS, d, r);
        check(d, 32'h0);
        u_host.rd(8'h20, d, r);
        check(d, 32'h0);
        check(r, vcs_pkg::RESP_SLVERR);
        u_host.wr(8'h24, 32'h1, r);
        check(r, vcs_pkg::RESP_SLVERR);
        u_host.wr(vcs_pkg::ADDR_COUNTS, 32'hFFFF_FFFF, r);
        u_host.rd(vcs_pkg::ADDR_COUNTS, d, r);
        check(d, 32'h1F1F);
        $display("reset and register test done");
    endtask : t_reset
    // Program, start, optionally restart while busy, wait for done
    task automatic run(input logic [9:0] to, input logic [4:0] st, input logic [4:0] lv,
                       input logic [7:0] bd, input bit again, output int cyc);
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        u_host.wr(vcs_pkg::ADDR_TIMEOUT, {22'h0, to}, r);
        u_host.wr(vcs_pkg::ADDR_COUNTS, {19'h0, lv, 3'h0, st}, r);
        u_host.wr(vcs_pkg::ADDR_BANDDIV, {24'h0, bd}, r);
        busy_n = 0;
        u_host.wr(vcs_pkg::ADDR_CTRL, 32'h1, r);
        check(r, vcs_pkg::RESP_OKAY);
        u_host.rd(vcs_pkg::ADDR_STATUS, d, r);
        check(d[1:0], 2'h1);
        // Second start lands past the settle phase, where a restart would show
        if (again) begin
            repeat (8) @(posedge clk);
            u_host.wr(vcs_pkg::ADDR_CTRL, 32'h1, r);
            check(r, vcs_pkg::RESP_OKAY);
        end
        for (n = 0; n < 70000 && cal_done !== 1'b1; n++) @(negedge clk);
        if (n == 70000) begin
            mismatches++;
            end_sim();
        end
        cyc = busy_n;
    endtask : run
    // Full run with host-chosen values at 20 MHz
    task automatic t_host();
        logic [31:0] d;
        logic [1:0]  r;
        logic [4:0]  st;
        int          e, c;
        st = 5'hA;
        e = int'(u_host.to_for(st)) * 10 + 176 * int'(u_host.div_for(20000000))
            + 55 * int'(u_host.lvl_for(st)) * int'(u_host.to_for(st));
        run(u_host.to_for(st), st, u_host.lvl_for(st), u_host.div_for(20000000), 0, c);
        check(c, e + 1);
        u_host.rd(vcs_pkg::ADDR_STATUS, d, r);
        check(d[5:0], 6'h02);
        $display("host run test done");
    endtask : t_host
    // Settle, level-wait and band divider each move the run length by their own exact step
    task automatic t_delta();
        int b, c;
        run(10'h2, 5'h3, 5'h2, 8'h1, 0, b);
        run(10'h2, 5'h5, 5'h2, 8'h1, 0, c);
        check(c - b, 4);
        run(10'h2, 5'h3, 5'h2, 8'h2, 0, c);
        check(c - b, 176);
        run(10'h2, 5'h3, 5'h3, 8'h1, 0, c);
        check(c - b, 110);
        run(10'h2, 5'h3, 5'h2, 8'h1, 1, c);
        check(c, b);
        $display("phase length test done");
    endtask : t_delta
    // Reset in mid-run stops the sequencer and restores defaults
    task automatic t_midreset();
        logic [31:0] d;
        logic [1:0]  r;
        u_host.wr(vcs_pkg::ADDR_CTRL, 32'h1, r);
        u_host.rd(vcs_pkg::ADDR_STATUS, d, r);
        check(d[1:0], 2'h1);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({awready, wready, arready, bvalid, rvalid, cal_busy, cal_done}, 7'h70);
        @(posedge clk);
        rst_n <= 1'b1;
        u_host.rd(vcs_pkg::ADDR_TIMEOUT, d, r);
        check(d, 32'h67);
        u_host.rd(vcs_pkg::ADDR_STATUS, d, r);
        check(d, 32'h0);
        $display("mid-run reset test done");
    endtask : t_midreset
    initial begin
        rst_n = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_host();
        t_delta();
        t_midreset();
        end_sim();
    end
endmodule : vcs_top_bench
